//--- rtl/dual_alu_datapath.sv
// dual 16-bit alu datapath with operand, result, cache and readback paths
// How it works
// - operands picked by four muxes, two per unit, held one cycle in operand registers
// - two 16-bit alus run in parallel, each with own operand registers
// - on same-rank writes to one register, second unit wins
// - units independent normally, joinable for one 32-bit operation
// - shared sources reach both units; private registers reach only one
// - each result passes shifter: left, right, byte swap or pass
// - zero, carry and overflow flags per alu output
// - negative flag per shifter output (positive implied)
// - shifter outputs form result buses written back to registers
// - memory data register loads from holding registers or result buses
// - cache address: bank high, low from address registers or result buses
// - first address register feeds store loading and return address
// - cache read error into next instruction register raises cache error
// - table and microword readable over two 16-bit readback buses
// - stack count register tracks valid top-of-stack registers
// - counter registers forwarded as address to overhead mux
// - interrupt data registers feed operands and interrupt decode
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module dual_alu_datapath #(
  parameter int W = dual_alu_pkg::DataWidth
) (
  input wire logic mclk,
  input wire logic reset_n,
  // microword control
  input wire logic [3:0] firstSelA,
  input wire logic [3:0] secondSelA,
  input wire logic [3:0] firstSelB,
  input wire logic [3:0] secondSelB,
  input wire logic [2:0] aluOpA,
  input wire logic [2:0] aluOpB,
  input wire logic [1:0] shiftOpA,
  input wire logic [1:0] shiftOpB,
  input wire logic [1:0] destA,
  input wire logic [1:0] destB,
  input wire logic writeA,
  input wire logic writeB,
  input wire logic [1:0] mdataSel,
  input wire logic mdataLoad,
  input wire logic [1:0] caddrSel,
  input wire logic [15:0] bankReg,
  input wire logic [W-1:0] holdDataA,
  input wire logic [W-1:0] holdDataB,
  input wire logic [W-1:0] addrRegA,
  input wire logic [W-1:0] addrRegB,
  input wire logic [W-1:0] cacheData,
  input wire logic [W-1:0] auxStackPtr,
  input wire logic [W-1:0] envReg,
  input wire logic [W-1:0] counterFirst,
  input wire logic [W-1:0] counterSecond,
  input wire logic [W-1:0] interruptDataFirst,
  input wire logic [W-1:0] interruptDataSecond,
  input wire logic [2:0] stackCntLoad,
  input wire logic stackCntWrite,
  input wire logic nirReadDone,
  input wire logic nirReadError,
  input wire logic [W-1:0] tableWord,
  input wire logic [W-1:0] instrWord,
  input wire logic [W-1:0] csorFirst,
  input wire logic [W-1:0] csorSecond,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // outputs
  output logic [W-1:0] firstResultBus,
  output logic [W-1:0] secondResultBus,
  output logic [W-1:0] processorDataBus,
  output logic [31:0] cacheAddressBus,
  output logic [W-1:0] storeLoadData,
  output logic [W-1:0] returnAddrData,
  output logic [W-1:0] overheadAddrFirst,
  output logic [W-1:0] overheadAddrSecond,
  output logic [W-1:0] interruptDecodeFirst,
  output logic [W-1:0] interruptDecodeSecond,
  output logic [W-1:0] tableReadbackBus,
  output logic [W-1:0] microwordReadbackBus,
  output logic cacheErrorSignal,
  output logic irq,
  output logic [7:0] condFlags
);
  logic [W-1:0] tos_r [dual_alu_pkg::TosCount];
  logic [dual_alu_pkg::SrWidth-1:0] stackCnt_r;
  logic [W-1:0] firstOpA_r, secondOpA_r, firstOpB_r, secondOpB_r;
  logic [W-1:0] muxFA, muxSA, muxFB, muxSB;
  logic [W:0] sumA, sumB;
  logic [W-1:0] first_arith_unit, second_arith_unit, shA, shB;
  logic carryA, carryB, ovfA, ovfB, joinCarry, cinA, cinB;
  logic [2:0] ctrl_r;
  logic [dual_alu_pkg::StatWidth-1:0] status_r, mask_r;
  logic [W-1:0] memory_data_reg_r;
  logic [31:0] caddr_r;
  logic [7:0] cond_r;
  logic [31:0] rdata_nxt;
  logic cacheErr_r;
  logic apbWrite, apbRead;

  // operand selector shared by both units; private picks differ per unit
  function automatic logic [W-1:0] pick(input logic [3:0] s, input logic [W-1:0] p0,
                                         input logic [W-1:0] p1);
    logic [W-1:0] v;
    v = '0;
    if (s < 4'(dual_alu_pkg::TosCount)) v = tos_r[s[1:0]];
    else if (s == dual_alu_pkg::SrcStackCnt) v = W'(stackCnt_r);
    else if (s == dual_alu_pkg::SrcAuxSp) v = auxStackPtr;
    else if (s == dual_alu_pkg::SrcEnv) v = envReg;
    else if (s == dual_alu_pkg::SrcCacheData) v = cacheData;
    else if (s == dual_alu_pkg::SrcResultA) v = firstResultBus;
    else if (s == dual_alu_pkg::SrcResultB) v = secondResultBus;
    else if (s == dual_alu_pkg::SrcPrivate0) v = p0;
    else if (s == dual_alu_pkg::SrcPrivate1) v = p1;
    return v;
  endfunction : pick

  function automatic logic [W:0] alu(input logic [2:0] op, input logic [W-1:0] r,
                                     input logic [W-1:0] s, input logic cin);
    logic [W:0] y;
    y = '0;
    case (op)
      dual_alu_pkg::OpAdd: y = {1'b0, r} + {1'b0, s} + (W+1)'(cin);
      dual_alu_pkg::OpSub: y = {1'b0, r} + {1'b0, ~s} + (W+1)'(cin);
      dual_alu_pkg::OpAnd: y = {1'b0, r & s};
      dual_alu_pkg::OpOr: y = {1'b0, r | s};
      dual_alu_pkg::OpXor: y = {1'b0, r ^ s};
      dual_alu_pkg::OpPassR: y = {1'b0, r};
      dual_alu_pkg::OpPassS: y = {1'b0, s};
      default: y = {1'b0, r} + (W+1)'(1'b1);
    endcase
    return y;
  endfunction : alu

  function automatic logic [W-1:0] shift(input logic [1:0] op, input logic [W-1:0] v);
    logic [W-1:0] y;
    y = v;
    case (op)
      dual_alu_pkg::ShLeft: y = {v[W-2:0], 1'b0};
      dual_alu_pkg::ShRight: y = {1'b0, v[W-1:1]};
      dual_alu_pkg::ShSwap: y = {v[W/2-1:0], v[W-1:W/2]};
      default: y = v;
    endcase
    return y;
  endfunction : shift

  // overflow only means something for add, subtract and increment
  function automatic logic ovf(input logic [2:0] op, input logic [W-1:0] r,
                               input logic [W-1:0] s, input logic [W-1:0] y);
    logic v;
    v = 1'b0;
    case (op)
      dual_alu_pkg::OpAdd: v = (r[W-1] == s[W-1]) && (y[W-1] != r[W-1]);
      dual_alu_pkg::OpSub: v = (r[W-1] != s[W-1]) && (y[W-1] != r[W-1]);
      dual_alu_pkg::OpInc: v = !r[W-1] && y[W-1];
      default: v = 1'b0;
    endcase
    return v;
  endfunction : ovf

  // private sources: first unit sees counters, second sees interrupt data
  // process form so stack and result changes re-evaluate the selectors
  always_comb begin
    muxFA = pick(firstSelA, counterFirst, counterSecond);
    muxSA = pick(secondSelA, counterFirst, counterSecond);
    muxFB = pick(firstSelB, interruptDataFirst, interruptDataSecond);
    muxSB = pick(secondSelB, interruptDataFirst, interruptDataSecond);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      firstOpA_r <= '0;
      secondOpA_r <= '0;
      firstOpB_r <= '0;
      secondOpB_r <= '0;
    end else begin
      firstOpA_r <= muxFA;
      secondOpA_r <= muxSA;
      firstOpB_r <= muxFB;
      secondOpB_r <= muxSB;
    end
  end

  // joined mode: first unit low half, carry chains into second unit
  // subtract takes carry in as not-borrow, so the low half starts at one
  assign cinA = aluOpA == dual_alu_pkg::OpSub;
  assign sumA = alu(aluOpA, firstOpA_r, secondOpA_r, cinA);
  assign joinCarry = ctrl_r[dual_alu_pkg::CtrlJoinBit] & sumA[W];
  assign cinB = ctrl_r[dual_alu_pkg::CtrlJoinBit] ? joinCarry :
    (aluOpB == dual_alu_pkg::OpSub);
  assign sumB = alu(aluOpB, firstOpB_r, secondOpB_r, cinB);
  assign first_arith_unit = sumA[W-1:0];
  assign second_arith_unit = sumB[W-1:0];
  assign carryA = sumA[W];
  assign carryB = sumB[W];
  assign ovfA = ovf(aluOpA, firstOpA_r, secondOpA_r, first_arith_unit);
  assign ovfB = ovf(aluOpB, firstOpB_r, secondOpB_r, second_arith_unit);
  assign shA = shift(shiftOpA, first_arith_unit);
  assign shB = shift(shiftOpB, second_arith_unit);
  assign firstResultBus = shA;
  assign secondResultBus = shB;

  // condition flags: zero carry ovf per alu; neg per shifter (pos implied)
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cond_r <= '0;
    else cond_r <= {second_arith_unit == '0, carryB, ovfB, shB[W-1],
                    first_arith_unit == '0, carryA, ovfA, shA[W-1]};
  end
  assign condFlags = {cond_r[7:1], cond_r[0]};

  // top-of-stack writeback; second unit wins a shared destination
  for (genvar i = 0; i < dual_alu_pkg::TosCount; i++) begin : g_tos
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) tos_r[i] <= '0;
      else if (writeB && destB == 2'(i)) tos_r[i] <= shB;
      else if (writeA && destA == 2'(i)) tos_r[i] <= shA;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) stackCnt_r <= '0;
    else if (stackCntWrite) stackCnt_r <= stackCntLoad;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) memory_data_reg_r <= '0;
    else if (mdataLoad) begin
      case (mdataSel)
        dual_alu_pkg::MdHoldA: memory_data_reg_r <= holdDataA;
        dual_alu_pkg::MdHoldB: memory_data_reg_r <= holdDataB;
        dual_alu_pkg::MdBusA: memory_data_reg_r <= shA;
        default: memory_data_reg_r <= shB;
      endcase
    end
  end
  assign processorDataBus = memory_data_reg_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) caddr_r <= '0;
    else begin
      case (caddrSel)
        dual_alu_pkg::CaAddrA: caddr_r <= {bankReg, addrRegA};
        dual_alu_pkg::CaAddrB: caddr_r <= {bankReg, addrRegB};
        dual_alu_pkg::CaBusA: caddr_r <= {bankReg, shA};
        default: caddr_r <= {bankReg, shB};
      endcase
    end
  end
  assign cacheAddressBus = caddr_r;

  assign storeLoadData = addrRegA;
  assign returnAddrData = addrRegA;
  assign overheadAddrFirst = counterFirst;
  assign overheadAddrSecond = counterSecond;
  assign interruptDecodeFirst = interruptDataFirst;
  assign interruptDecodeSecond = interruptDataSecond;
  assign tableReadbackBus = ctrl_r[dual_alu_pkg::CtrlRbSelBit] ? instrWord : tableWord;
  assign microwordReadbackBus = ctrl_r[dual_alu_pkg::CtrlCsorSelBit] ? csorSecond : csorFirst;

  // cache error level; held until reset (halts processor)
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) cacheErr_r <= 1'b0;
    else if (nirReadDone && nirReadError) cacheErr_r <= 1'b1;
  end
  assign cacheErrorSignal = cacheErr_r;

  // apb slave, zero wait states
  assign apbWrite = psel && penable && pwrite;
  assign apbRead = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= '0;
      mask_r <= '0;
    end else if (apbWrite && paddr == dual_alu_pkg::AddrCtrl) ctrl_r <= pwdata[2:0];
    else if (apbWrite && paddr == dual_alu_pkg::AddrMask)
      mask_r <= pwdata[dual_alu_pkg::StatWidth-1:0];
  end

  // sticky status; a set in the clear cycle wins
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) status_r <= '0;
    else begin
      status_r[dual_alu_pkg::StatCacheErr] <= (nirReadDone && nirReadError) ||
        (status_r[dual_alu_pkg::StatCacheErr] &&
         !(apbWrite && paddr == dual_alu_pkg::AddrStatus &&
           pwdata[dual_alu_pkg::StatCacheErr]));
      status_r[dual_alu_pkg::StatOverflow] <= (ovfA || ovfB) ||
        (status_r[dual_alu_pkg::StatOverflow] &&
         !(apbWrite && paddr == dual_alu_pkg::AddrStatus &&
           pwdata[dual_alu_pkg::StatOverflow]));
    end
  end
  assign irq = |(status_r & mask_r);

  always_comb begin
    rdata_nxt = dual_alu_pkg::ResetWord;
    if (paddr == dual_alu_pkg::AddrCtrl) rdata_nxt = 32'(ctrl_r);
    else if (paddr == dual_alu_pkg::AddrStatus) rdata_nxt = 32'(status_r);
    else if (paddr == dual_alu_pkg::AddrMask) rdata_nxt = 32'(mask_r);
    else if (paddr == dual_alu_pkg::AddrResultA) rdata_nxt = 32'(shA);
    else if (paddr == dual_alu_pkg::AddrResultB) rdata_nxt = 32'(shB);
    else if (paddr == dual_alu_pkg::AddrCond) rdata_nxt = 32'(cond_r);
    else if (paddr == dual_alu_pkg::AddrCacheAddr) rdata_nxt = caddr_r;
    else if (paddr == dual_alu_pkg::AddrMdata) rdata_nxt = 32'(memory_data_reg_r);
    else if (paddr == dual_alu_pkg::AddrStackCnt) rdata_nxt = 32'(stackCnt_r);
    else if (paddr == dual_alu_pkg::AddrReadback)
      rdata_nxt = {microwordReadbackBus, tableReadbackBus};
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) prdata <= '0;
    else if (apbRead && !penable) prdata <= rdata_nxt;
  end

  // assertions
  a_operand_hold_one: assert property (@(posedge mclk) disable iff (!reset_n)
    firstOpA_r == $past(muxFA)) else $error("operand register not one-cycle copy");
  a_second_wins_tos: assert property (@(posedge mclk) disable iff (!reset_n)
    writeA && writeB && destA == destB |=> tos_r[$past(destB)] == $past(shB))
    else $error("second unit lost write priority");
  a_tos_writeback: assert property (@(posedge mclk) disable iff (!reset_n)
    writeB |=> tos_r[$past(destB)] == $past(shB)) else $error("result not written back");
  a_join_carry_chain: assert property (@(posedge mclk) disable iff (!reset_n)
    !ctrl_r[dual_alu_pkg::CtrlJoinBit] && aluOpB == dual_alu_pkg::OpAdd |->
    sumB == {1'b0, firstOpB_r} + {1'b0, secondOpB_r})
    else $error("carry chained while not joined");
  a_join_carry_feed: assert property (@(posedge mclk) disable iff (!reset_n)
    ctrl_r[dual_alu_pkg::CtrlJoinBit] && carryA && aluOpB == dual_alu_pkg::OpAdd |->
    second_arith_unit == W'(firstOpB_r + secondOpB_r + 1'b1))
    else $error("joined carry not added");
  a_zero_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    first_arith_unit == '0 |=> cond_r[3]) else $error("zero flag missing");
  a_ovf_logic_ops: assert property (@(posedge mclk) disable iff (!reset_n)
    aluOpA inside {dual_alu_pkg::OpAnd, dual_alu_pkg::OpOr, dual_alu_pkg::OpXor} |=>
    !cond_r[1]) else $error("overflow flagged on a logic operation");
  a_neg_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    shB[W-1] |=> cond_r[4]) else $error("negative flag missing");
  sequence s_md_load;
    mdataLoad && mdataSel == dual_alu_pkg::MdHoldA;
  endsequence
  a_memory_data_reg_load: assert property (@(posedge mclk) disable iff (!reset_n)
    s_md_load |=> processorDataBus == $past(holdDataA))
    else $error("memory data not loaded from holding register");
  a_cache_bank: assert property (@(posedge mclk) disable iff (!reset_n)
    1'b1 |=> cacheAddressBus[31:16] == $past(bankReg))
    else $error("cache address upper half not bank");
  a_cache_error: assert property (@(posedge mclk) disable iff (!reset_n)
    nirReadDone && nirReadError |=> cacheErrorSignal [*2])
    else $error("cache error not raised");
  a_stack_count: assert property (@(posedge mclk) disable iff (!reset_n)
    stackCntWrite |=> stackCnt_r == $past(stackCntLoad))
    else $error("stack count not loaded");
endmodule : dual_alu_datapath

//--- rtl/dual_alu_pkg.sv
// constants and types shared by the dual alu datapath
package dual_alu_pkg;
  localparam int DataWidth = 16;
  localparam int TosCount = 4;
  localparam int SrWidth = 3;
  // apb register byte addresses
  localparam logic [7:0] AddrCtrl = 8'h00;
  localparam logic [7:0] AddrStatus = 8'h04;
  localparam logic [7:0] AddrMask = 8'h08;
  localparam logic [7:0] AddrResultA = 8'h0C;
  localparam logic [7:0] AddrResultB = 8'h10;
  localparam logic [7:0] AddrCond = 8'h14;
  localparam logic [7:0] AddrCacheAddr = 8'h18;
  localparam logic [7:0] AddrMdata = 8'h1C;
  localparam logic [7:0] AddrStackCnt = 8'h20;
  localparam logic [7:0] AddrReadback = 8'h24;
  // control register fields
  localparam int CtrlJoinBit = 0;
  localparam int CtrlRbSelBit = 1;
  localparam int CtrlCsorSelBit = 2;
  // status / mask bits
  localparam int StatCacheErr = 0;
  localparam int StatOverflow = 1;
  localparam int StatWidth = 2;
  localparam logic [31:0] ResetWord = 32'h0000_0000;

  typedef enum logic [2:0] {
    OpAdd = 3'b000, OpSub = 3'b001, OpAnd = 3'b010, OpOr = 3'b011,
    OpXor = 3'b100, OpPassR = 3'b101, OpPassS = 3'b110, OpInc = 3'b111
  } alu_op_t;
  typedef enum logic [1:0] {
    ShPass = 2'b00, ShLeft = 2'b01, ShRight = 2'b10, ShSwap = 2'b11
  } shift_op_t;
  // shared operand sources 0..9, private ones 10..11
  typedef enum logic [3:0] {
    SrcTos0 = 4'h0, SrcTos1 = 4'h1, SrcTos2 = 4'h2, SrcTos3 = 4'h3,
    SrcStackCnt = 4'h4, SrcAuxSp = 4'h5, SrcEnv = 4'h6, SrcCacheData = 4'h7,
    SrcResultA = 4'h8, SrcResultB = 4'h9, SrcPrivate0 = 4'hA, SrcPrivate1 = 4'hB
  } src_sel_t;
  typedef enum logic [1:0] {
    MdHoldA = 2'b00, MdHoldB = 2'b01, MdBusA = 2'b10, MdBusB = 2'b11
  } memory_data_reg_sel_t;
  typedef enum logic [1:0] {
    CaAddrA = 2'b00, CaAddrB = 2'b01, CaBusA = 2'b10, CaBusB = 2'b11
  } caddr_sel_t;
endpackage : dual_alu_pkg

//--- test/cache_side_model.sv
// cache memory and control store side feeding the datapath
`timescale 1ns/1ps
module cache_side_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic readReq,
  input wire logic readErr,
  output logic [15:0] cacheData,
  output logic nirReadDone,
  output logic nirReadError,
  output logic [15:0] tableWord,
  output logic [15:0] instrWord,
  output logic [15:0] csorFirst,
  output logic [15:0] csorSecond
);
  logic [2:0] waitCnt_r;
  logic errHeld_r;
  logic slow_r;
  // arbitrary readback contents
  assign tableWord = 16'h1A2B;
  assign instrWord = 16'h3C4D;
  assign csorFirst = 16'h5E6F;
  assign csorSecond = 16'h7A8B;
  // reads alternate between a prompt and a slow answer
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {waitCnt_r, errHeld_r, slow_r, nirReadDone, nirReadError} <= '0;
      cacheData <= 16'hC0DE;
    end else begin
      nirReadDone <= 1'b0;
      nirReadError <= 1'b0;
      if (readReq) begin
        waitCnt_r <= slow_r ? 3'h4 : 3'h1;
        errHeld_r <= readErr;
        slow_r <= !slow_r;
      end else if (waitCnt_r == 3'h1) begin
        nirReadDone <= 1'b1;
        nirReadError <= errHeld_r;
        cacheData <= cacheData + 16'h1357;
        waitCnt_r <= 3'h0;
      end else if (waitCnt_r != 3'h0) begin
        waitCnt_r <= waitCnt_r - 3'h1;
      end
    end
  end
endmodule : cache_side_model

//--- test/dual_alu_register_datapath_tb_top.sv
// self-checking bench for the dual alu datapath
`timescale 1ns/1ps
module dual_alu_register_datapath_tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] firstSelA, secondSelA, firstSelB, secondSelB;
  logic [2:0] aluOpA, aluOpB, stackCntLoad;
  logic [1:0] shiftOpA, shiftOpB, destA, destB, mdataSel, caddrSel;
  logic writeA, writeB, mdataLoad, stackCntWrite, psel, penable, pwrite, readReq, readErr;
  logic nirReadDone, nirReadError, pready, pslverr, cacheErrorSignal, irq;
  logic [7:0] paddr, condFlags, fl, m;
  logic [31:0] pwdata, prdata, cacheAddressBus, q;
  logic [15:0] bankReg, holdDataA, holdDataB, addrRegA, addrRegB, cacheData, auxStackPtr, envReg;
  logic [15:0] counterFirst, counterSecond, interruptDataFirst, interruptDataSecond;
  logic [15:0] tableWord, instrWord, csorFirst, csorSecond, firstResultBus, secondResultBus;
  logic [15:0] processorDataBus, storeLoadData, returnAddrData, overheadAddrFirst;
  logic [15:0] overheadAddrSecond, interruptDecodeFirst, interruptDecodeSecond;
  logic [15:0] tableReadbackBus, microwordReadbackBus, rnd, e, e2, exA, exB;
  logic [15:0] exMd = 16'h0;
  logic [15:0] seed = 16'h53E9;
  logic [15:0] tosV [4];
  logic [16:0] ra, rb;
  logic [7:0] regs [5] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h3C};
  int errorCnt = 0;
  int nCompared = 0;
  int n;

  dual_alu_datapath dual_alu_datapath_inst (.mclk, .reset_n, .firstSelA, .secondSelA,
    .firstSelB, .secondSelB, .aluOpA, .aluOpB, .shiftOpA, .shiftOpB, .destA, .destB, .writeA,
    .writeB, .mdataSel, .mdataLoad, .caddrSel, .bankReg, .holdDataA, .holdDataB, .addrRegA,
    .addrRegB, .cacheData, .auxStackPtr, .envReg, .counterFirst, .counterSecond,
    .interruptDataFirst, .interruptDataSecond, .stackCntLoad, .stackCntWrite, .nirReadDone,
    .nirReadError, .tableWord, .instrWord, .csorFirst, .csorSecond, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .firstResultBus, .secondResultBus,
    .processorDataBus, .cacheAddressBus, .storeLoadData, .returnAddrData, .overheadAddrFirst,
    .overheadAddrSecond, .interruptDecodeFirst, .interruptDecodeSecond, .tableReadbackBus,
    .microwordReadbackBus, .cacheErrorSignal, .irq, .condFlags);
  cache_side_model cache_side_model_inst (.mclk, .reset_n, .readReq, .readErr, .cacheData,
    .nirReadDone, .nirReadError, .tableWord, .instrWord, .csorFirst, .csorSecond);

  always #20 mclk = ~mclk;

  function automatic logic [15:0] rand16();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rand16

  function automatic logic [16:0] alu(input logic [2:0] op, input logic [15:0] r, s,
                                      input logic c);
    case (op)
      3'h0: return {1'b0, r} + {1'b0, s} + {16'h0, c};
      3'h1: return {1'b0, r - s};
      3'h2: return {1'b0, r & s};
      3'h3: return {1'b0, r | s};
      3'h4: return {1'b0, r ^ s};
      3'h5: return {1'b0, r};
      3'h6: return {1'b0, s};
      default: return {1'b0, r + 16'h1};
    endcase
  endfunction : alu

  function automatic logic [15:0] sh(input logic [1:0] op, input logic [15:0] v);
    case (op)
      2'h1: return {v[14:0], 1'b0};
      2'h2: return {1'b0, v[15:1]};
      2'h3: return {v[7:0], v[15:8]};
      default: return v;
    endcase
  endfunction : sh

  function automatic logic ovf(input logic [15:0] a, b, y);
    return (a[15] == b[15]) && (y[15] != a[15]);
  endfunction : ovf

  function automatic logic [15:0] pick(input logic [1:0] s, input logic [15:0] a, b, c, d);
    return s[1] ? (s[0] ? d : c) : (s[0] ? b : a);
  endfunction : pick

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stopTest();
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stopTest

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) errorCnt++;
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask : apb

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #400000;
    errorCnt++;
    stopTest();
  end

  initial begin
    {firstSelA, secondSelA, firstSelB, secondSelB, aluOpA, aluOpB, shiftOpA, shiftOpB, destA,
     destB, writeA, writeB, mdataSel, mdataLoad, caddrSel, bankReg, holdDataA, holdDataB,
     addrRegA, addrRegB, auxStackPtr, envReg, counterFirst, counterSecond, interruptDataFirst,
     interruptDataSecond, stackCntLoad, stackCntWrite, psel, penable, pwrite, paddr, pwdata,
     readReq, readErr} = '0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (regs[i]) begin
      apb(regs[i], 1'b0, 32'h0);
      check("reset value", q, 32'h0);
    end
    apb(8'h3C, 1'b1, 32'hFFFF_FFFF);
    apb(8'h3C, 1'b0, 32'h0);
    check("unmapped read", q, 32'h0);
    $display("done: registers");
    {firstSelA, secondSelA, firstSelB, secondSelB} <= 16'hABAB;
    for (int j = 0; j < 2; j++) begin
      if (j == 1) apb(dual_alu_pkg::AddrCtrl, 1'b1, 32'h1);
      for (int i = 0; i < 24; i++) begin
        @(posedge mclk);
        rnd = rand16();
        {aluOpA, aluOpB} <= (j == 1) ? 6'h0 : rnd[5:0];
        {shiftOpA, shiftOpB, mdataSel, caddrSel} <= (j == 1) ? {4'h0, rnd[9:6]} : rnd[13:6];
        mdataLoad <= rnd[14];
        counterFirst <= rand16();
        counterSecond <= rand16();
        interruptDataFirst <= rand16();
        interruptDataSecond <= rand16();
        holdDataA <= rand16();
        holdDataB <= rand16();
        addrRegA <= rand16();
        addrRegB <= rand16();
        bankReg <= rand16();
        tick();
        ra = alu(aluOpA, counterFirst, counterSecond, 1'b0);
        rb = alu(aluOpB, interruptDataFirst, interruptDataSecond, (j == 1) && ra[16]);
        exA = sh(shiftOpA, ra[15:0]);
        exB = sh(shiftOpB, rb[15:0]);
        check("result buses", {secondResultBus, firstResultBus}, {exB, exA});
        check("address feed", {storeLoadData, returnAddrData}, {addrRegA, addrRegA});
        check("counter feed", {overheadAddrFirst, overheadAddrSecond},
              {counterFirst, counterSecond});
        check("interrupt feed", {interruptDecodeFirst, interruptDecodeSecond},
              {interruptDataFirst, interruptDataSecond});
        if (mdataLoad) exMd = pick(mdataSel, holdDataA, holdDataB, exA, exB);
        tick();
        fl = {rb[15:0] == 16'h0, rb[16], ovf(interruptDataFirst, interruptDataSecond, rb[15:0]),
              exB[15], ra[15:0] == 16'h0, ra[16], ovf(counterFirst, counterSecond, ra[15:0]),
              exA[15]};
        m = {1'b1, {2{aluOpB == 3'h0}}, 2'b11, aluOpA == 3'h0, aluOpA == 3'h0 && j == 0, 1'b1};
        check("cond flags", {24'h0, condFlags & m}, {24'h0, fl & m});
        check("memory data", {16'h0, processorDataBus}, {16'h0, exMd});
        check("cache address", cacheAddressBus,
              {bankReg, pick(caddrSel, addrRegA, addrRegB, exA, exB)});
      end
    end
    $display("done: alu paths");
    for (int v = 0; v < 4; v++) begin
      apb(dual_alu_pkg::AddrCtrl, 1'b1, 32'(v) << 1);
      apb(dual_alu_pkg::AddrReadback, 1'b0, 32'h0);
      #1;
      e = v[0] ? instrWord : tableWord;
      e2 = v[1] ? csorSecond : csorFirst;
      check("readback buses", {microwordReadbackBus, tableReadbackBus}, {e2, e});
      check("readback reg", q, {e2, e});
    end
    $display("done: readback");
    @(posedge mclk);
    {stackCntLoad, stackCntWrite} <= 4'h7;
    @(posedge mclk);
    stackCntWrite <= 1'b0;
    apb(dual_alu_pkg::AddrStackCnt, 1'b0, 32'h0);
    check("stack count", q, 32'h3);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      {aluOpA, aluOpB, shiftOpA, shiftOpB} <= {3'h5, 3'h5, 4'h0};
      counterFirst <= rand16();
      interruptDataFirst <= rand16();
      @(posedge mclk);
      {writeA, writeB, destA, destB} <= {2'b11, 2'(k), 2'(k)};
      @(posedge mclk);
      {writeA, writeB} <= 2'b00;
      tosV[k] = interruptDataFirst;
    end
    @(posedge mclk);
    auxStackPtr <= rand16();
    envReg <= rand16();
    for (int s = 0; s < 9; s++) begin
      @(posedge mclk);
      firstSelA <= (s > 7) ? 4'h7 : 4'(s);
      firstSelB <= 4'(s);
      tick();
      case (s)
        0, 1, 2, 3: e = tosV[s];
        4: e = 16'h0003;
        5: e = auxStackPtr;
        6: e = envReg;
        default: e = cacheData;
      endcase
      check("shared source", {secondResultBus, firstResultBus}, {e, e});
    end
    $display("done: write back");
    apb(dual_alu_pkg::AddrMask, 1'b1, 32'h1);
    for (int t = 0; t < 3; t++) begin
      @(posedge mclk);
      {readReq, readErr} <= {1'b1, t == 2};
      @(posedge mclk);
      readReq <= 1'b0;
      n = 0;
      do begin
        tick();
        n++;
      end while (nirReadDone !== 1'b1 && n < 20);
      if (n >= 20) errorCnt++;
      tick();
      check("error and irq", {30'h0, irq, cacheErrorSignal}, {30'h0, t == 2, t == 2});
    end
    apb(dual_alu_pkg::AddrStatus, 1'b0, 32'h0);
    check("status", {31'h0, q[0]}, 32'h1);
    apb(dual_alu_pkg::AddrMask, 1'b1, 32'h0);
    #1;
    check("masked irq", {31'h0, irq}, 32'h0);
    apb(dual_alu_pkg::AddrMask, 1'b1, 32'h1);
    apb(dual_alu_pkg::AddrStatus, 1'b1, 32'h1);
    #1;
    check("cleared irq", {30'h0, irq, cacheErrorSignal}, 32'h1);
    $display("done: cache error");
    stopTest();
  end
endmodule : dual_alu_register_datapath_tb_top
